/* crt_params.svh */
/*
 Constants for the capture/reload timer: register offsets, control bit positions, timing counts.
 Assumes inclusion by bare name from the timer's design files.
*/
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets on APB
// ----------------------------------------
`define CRT_OFS_CONTROL 12'h000
`define CRT_OFS_COUNT 12'h004
`define CRT_OFS_RELOAD 12'h008
`define CRT_OFS_SERIAL 12'h00C

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define CRT_B_CAPSEL 0
`define CRT_B_CTSEL 1
`define CRT_B_RUN 2
`define CRT_B_EXEN 3
`define CRT_B_TXSEL 4
`define CRT_B_RXSEL 5
`define CRT_B_EXF 6
`define CRT_B_OVF 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CRT_CTRL_RESET 8'h00
`define CRT_COUNT_RESET 16'h0000
`define CRT_COUNT_MAX 16'hFFFF
`define CRT_OSC_PER_TICK 12
`define CRT_PRESCALE_MAX 4'hB

`endif

/* crt_pkg.sv */
/*
 Types shared by the capture/reload timer modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package crt_pkg;

	// ----------------------------------------
	// Operating modes, one-hot
	// ----------------------------------------
	typedef enum logic [3:0] {
		CRT_OFF = 4'h1,
		CRT_RELOAD = 4'h2,
		CRT_CAPTURE = 4'h4,
		CRT_BAUD = 4'h8
	} crt_mode_t;

endpackage

/* crt_event_if.sv */
/*
 Carrier between the timer core and its input conditioner.
 Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
interface crt_event_if;
	logic countFall;
	logic triggerFall;
	logic tick;
	modport source (output countFall, output triggerFall, output tick);
	modport sink (input countFall, input triggerFall, input tick);
endinterface // crt_event_if

/* crt_pin_sync.sv */
/*
 Synchronises the count and trigger pins, detects falling edges, and makes the
 one-in-twelve timer tick.
 Assumes pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "crt_params.svh"
module crt_pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Pins
	input wire logic countPin,
	input wire logic triggerPin,
	// Events
	crt_event_if.source ev
);
	typedef struct packed {
		logic [2:0] cntSync;
		logic [2:0] trgSync;
		logic cntLevel;
		logic trgLevel;
		logic cntFall;
		logic trgFall;
		logic [3:0] prescale;
		logic tick;
	} crt_sync_state_t;

	crt_sync_state_t st_r;
	crt_sync_state_t st_nxt;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.cntSync = {st_r.cntSync[1:0], countPin};
		st_nxt.trgSync = {st_r.trgSync[1:0], triggerPin};
		st_nxt.cntFall = 1'b0;
		st_nxt.trgFall = 1'b0;
		// Change counts once stages two and three agree
		if (st_r.cntSync[1] == st_r.cntSync[2]) begin
			st_nxt.cntLevel = st_r.cntSync[2];
			st_nxt.cntFall = st_r.cntLevel & ~st_r.cntSync[2]; // [RQ12]
		end
		if (st_r.trgSync[1] == st_r.trgSync[2]) begin
			st_nxt.trgLevel = st_r.trgSync[2];
			st_nxt.trgFall = st_r.trgLevel & ~st_r.trgSync[2]; // [RQ5]
		end
		// One tick per twelve oscillator periods
		st_nxt.tick = (st_r.prescale == `CRT_PRESCALE_MAX); // [RQ12]
		st_nxt.prescale = st_nxt.tick ? 4'h0 : st_r.prescale + 4'h1;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{cntSync: 3'h7, trgSync: 3'h7, cntLevel: 1'b1, trgLevel: 1'b1,
				cntFall: 1'b0, trgFall: 1'b0, prescale: 4'h0, tick: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ev.countFall = st_r.cntFall;
	assign ev.triggerFall = st_r.trgFall;
	assign ev.tick = st_r.tick;
endmodule // crt_pin_sync

/* crt_mode_decode.sv */
/*
 Decodes the operating mode from the control bits.
 Assumes control bits come from registers on mclk.
*/
`timescale 1ns/1ps
module crt_mode_decode (
	// Control
	input wire logic runControl,
	input wire logic captureSelect,
	input wire logic receiveClockSelect,
	input wire logic transmitClockSelect,
	// Mode
	output crt_pkg::crt_mode_t mode
);
	always_comb begin
		if (!runControl) begin
			mode = crt_pkg::CRT_OFF; // [RQ3]
		end else if (receiveClockSelect | transmitClockSelect) begin
			mode = crt_pkg::CRT_BAUD; // [RQ11]
		end else if (captureSelect) begin
			mode = crt_pkg::CRT_CAPTURE; // [RQ3]
		end else begin
			mode = crt_pkg::CRT_RELOAD; // [RQ3]
		end
	end
endmodule // crt_mode_decode

/* crt_timer.sv */
/*
 Capture/reload timer top: APB register slave, 16-bit counter, capture and reload
 logic, and serial baud clock selection.
 Assumes one 10 MHz mclk, asynchronous pins, and a serial port taking clock pulses.
*/
`timescale 1ns/1ps
`include "crt_params.svh"

// Functional notes
// [RQ1] Counter is sixteen bits, low and high bytes together.
// [RQ2] One control bit picks interval timer or external event counter.
// [RQ3] Run off means off; else clock selects, then capture select pick mode.
// [RQ4] Capture and reload modes set overflow flag on rollover; it requests interrupt.
// [RQ5] Trigger falling edge causing capture or reload sets external flag; software clears.
// [RQ6] External flag requests timer interrupt when enabled, like overflow flag.
// [RQ7] Clock selects route this timer's or the other timer's overflows to serial.
// [RQ8] Capture mode with trigger enabled copies count into capture registers on fall.
// [RQ9] Reload mode rollover sets overflow flag and reloads count from reload registers.
// [RQ10] Reload mode with trigger enabled also reloads on trigger fall, sets flag.
// [RQ11] Either clock select set means baud generator mode.
// [RQ12] Timer advances every twelve oscillator periods; counter on sampled falling edges.
// [RQ13] Baud mode sets no overflow flag, ignores capture select, always reloads.
module crt_timer #(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic countPin,
	input wire logic triggerPin,
	// Serial clock
	input wire logic otherTimerOverflow,
	output logic receiveClockPulse,
	output logic transmitClockPulse,
	// Interrupt request
	output logic timerIrq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] reload;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic rxPulse;
		logic txPulse;
		logic irq;
	} crt_state_t;

	crt_state_t st_r;
	crt_state_t st_nxt;
	crt_pkg::crt_mode_t mode;
	crt_event_if ev ();

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	crt_pin_sync u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.countPin(countPin),
		.triggerPin(triggerPin),
		.ev(ev)
	);

	crt_mode_decode u_mode (
		.runControl(st_r.ctrl[`CRT_B_RUN]),
		.captureSelect(st_r.ctrl[`CRT_B_CAPSEL]),
		.receiveClockSelect(st_r.ctrl[`CRT_B_RXSEL]),
		.transmitClockSelect(st_r.ctrl[`CRT_B_TXSEL]),
		.mode(mode)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic advance;
	logic rollover;
	logic trigEvent;
	logic setOvf;
	logic setExf;
	logic baudPulse;
	logic apbAccess;
	logic apbWrite;
	logic [7:0] ctrlWr;

	always_comb begin
		st_nxt = st_r;
		// Tick source by timer or counter select
		advance = st_r.ctrl[`CRT_B_CTSEL] ? ev.countFall : ev.tick; // [RQ2] [RQ12]
		if (mode == crt_pkg::CRT_OFF) begin
			advance = 1'b0;
		end
		rollover = advance && (st_r.count == COUNT_W'(`CRT_COUNT_MAX));
		trigEvent = ev.triggerFall && st_r.ctrl[`CRT_B_EXEN]
			&& (mode == crt_pkg::CRT_CAPTURE || mode == crt_pkg::CRT_RELOAD); // [RQ5]
		setOvf = rollover && (mode != crt_pkg::CRT_BAUD); // [RQ4] [RQ13]
		setExf = trigEvent; // [RQ5]
		baudPulse = rollover && (mode == crt_pkg::CRT_BAUD);
		apbAccess = psel && penable && !st_r.ready;
		// Write lands at the edge where the master samples pready high
		apbWrite = psel && penable && pwrite && st_r.ready;

		// Counter
		if (advance) begin
			st_nxt.count = st_r.count + COUNT_W'(1); // [RQ1]
		end
		if (rollover && mode != crt_pkg::CRT_CAPTURE) begin
			st_nxt.count = st_r.reload; // [RQ9] [RQ13]
		end
		if (trigEvent && mode == crt_pkg::CRT_RELOAD) begin
			st_nxt.count = st_r.reload; // [RQ10]
		end
		if (trigEvent && mode == crt_pkg::CRT_CAPTURE) begin
			st_nxt.reload = st_r.count; // [RQ8]
		end

		// Register reads and writes
		st_nxt.ready = apbAccess;
		st_nxt.slverr = 1'b0;
		st_nxt.rdata = 32'h0000_0000;
		if (apbAccess) begin
			unique case (paddr)
				`CRT_OFS_CONTROL: st_nxt.rdata = {24'h00_0000, st_r.ctrl};
				`CRT_OFS_COUNT: st_nxt.rdata = 32'(st_r.count);
				`CRT_OFS_RELOAD: st_nxt.rdata = 32'(st_r.reload);
				`CRT_OFS_SERIAL: st_nxt.rdata = 32'h0000_0000;
				default: st_nxt.slverr = 1'b1;
			endcase
		end
		if (apbWrite && paddr == `CRT_OFS_CONTROL) begin
			ctrlWr = pwdata[7:0];
		end else begin
			ctrlWr = st_r.ctrl;
		end
		st_nxt.ctrl = ctrlWr;
		// Hardware set wins over a software clear
		if (setOvf) begin
			st_nxt.ctrl[`CRT_B_OVF] = 1'b1; // [RQ4]
		end
		if (setExf) begin
			st_nxt.ctrl[`CRT_B_EXF] = 1'b1; // [RQ5]
		end
		if (apbWrite && paddr == `CRT_OFS_COUNT) begin
			st_nxt.count = pwdata[COUNT_W-1:0];
		end
		if (apbWrite && paddr == `CRT_OFS_RELOAD) begin
			st_nxt.reload = pwdata[COUNT_W-1:0];
		end

		// Serial clock source selection and interrupt request
		st_nxt.rxPulse = st_r.ctrl[`CRT_B_RXSEL] ? baudPulse : otherTimerOverflow; // [RQ7]
		st_nxt.txPulse = st_r.ctrl[`CRT_B_TXSEL] ? baudPulse : otherTimerOverflow; // [RQ7]
		st_nxt.irq = st_nxt.ctrl[`CRT_B_OVF] | st_nxt.ctrl[`CRT_B_EXF]; // [RQ4] [RQ6]
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{ctrl: `CRT_CTRL_RESET, count: COUNT_W'(`CRT_COUNT_RESET),
				reload: COUNT_W'(`CRT_COUNT_RESET), rdata: 32'h0000_0000, ready: 1'b0,
				slverr: 1'b0, rxPulse: 1'b0, txPulse: 1'b0, irq: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.slverr;
	assign receiveClockPulse = st_r.rxPulse;
	assign transmitClockPulse = st_r.txPulse;
	assign timerIrq = st_r.irq;
endmodule // crt_timer

/* crt_timer_asserts.sv */
/*
 Checker on the ports of crt_timer.
 Assumes it is bound into crt_timer.
*/
`timescale 1ns/1ps
module crt_timer_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Serial clock and interrupt
	input wire logic otherTimerOverflow,
	input wire logic receiveClockPulse,
	input wire logic timerIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_has_req: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without request");
	a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0))
		else $error("error flag wrong for address");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	a_quiet_after_reset: assert property ($rose(nrst) |-> !timerIrq && !pready)
		else $error("output high after reset");
	a_rx_pulse_single: assert property (receiveClockPulse && !$past(otherTimerOverflow) |=> !receiveClockPulse)
		else $error("serial clock pulse too long");
endmodule // crt_timer_asserts

bind crt_timer crt_timer_asserts crt_timer_asserts_i (.*);

/* crt_pin_model.sv */
/*
 Far side: count pin, trigger pin, other timer's overflow.
 Assumes mclk from the bench.
*/
`timescale 1ns/1ps
module crt_pin_model (
	// Clock
	input wire logic mclk,
	// Pins
	output logic countPin,
	output logic triggerPin,
	output logic otherTimerOverflow
);
	initial begin
		countPin = 1'b1;
		triggerPin = 1'b1;
		otherTimerOverflow = 1'b0;
	end
	// Each level held 8 cycles so the synchroniser sees it
	task automatic fall(input bit trig);
		@(posedge mclk);
		if (trig) triggerPin <= 1'b0;
		else countPin <= 1'b0;
		repeat (8) @(posedge mclk);
		triggerPin <= 1'b1;
		countPin <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
	task automatic other_pulse();
		@(posedge mclk);
		otherTimerOverflow <= 1'b1;
		@(posedge mclk);
		otherTimerOverflow <= 1'b0;
	endtask
endmodule // crt_pin_model

/* crt_timer_tb_top.sv */
/*
 Testbench for crt_timer over APB.
 Assumes crt_pin_model drives the pins.
*/
`timescale 1ns/1ps
module crt_timer_tb_top;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic countPin, triggerPin, otherTimerOverflow, receiveClockPulse, transmitClockPulse, timerIrq;
	int failures = 0;
	int n_checks = 0;
	int nRx = 0;
	int nTx = 0;
	crt_timer crt_timer_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.countPin(countPin), .triggerPin(triggerPin), .otherTimerOverflow(otherTimerOverflow),
		.receiveClockPulse(receiveClockPulse), .transmitClockPulse(transmitClockPulse), .timerIrq(timerIrq));
	crt_pin_model crt_pin_model_i (.mclk(mclk), .countPin(countPin), .triggerPin(triggerPin),
		.otherTimerOverflow(otherTimerOverflow));
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (receiveClockPulse === 1'b1) nRx++;
		if (transmitClockPulse === 1'b1) nTx++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge mclk);
		failures++;
		stop_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b1, 12'h010, 32'hFF);
		check(err, 1'b1);
		rdc(12'h012, 32'h0);
		check(err, 1'b1);
		rdc(12'h000, 32'h0);
		rdc(12'h004, 32'h0);
		apb(1'b1, 12'h008, 32'hFFF0);
		apb(1'b1, 12'h004, 32'hFFFE);
		apb(1'b1, 12'h000, 32'h04);
		repeat (40) @(posedge mclk);
		rdc(12'h000, 32'h84);
		check(timerIrq, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		check(rd & 32'hFFF0, 32'hFFF0);
		apb(1'b1, 12'h000, 32'h0);
		rdc(12'h000, 32'h0);
		check(timerIrq, 1'b0);
		apb(1'b1, 12'h004, 32'h0100);
		repeat (40) @(posedge mclk);
		rdc(12'h004, 32'h0100);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h06);
		repeat (3) crt_pin_model_i.fall(1'b0);
		rdc(12'h004, 32'h3);
		apb(1'b1, 12'h004, 32'h1234);
		apb(1'b1, 12'h000, 32'h0F);
		crt_pin_model_i.fall(1'b1);
		rdc(12'h008, 32'h1234);
		rdc(12'h000, 32'h4F);
		check(timerIrq, 1'b1);
		apb(1'b1, 12'h000, 32'h07);
		crt_pin_model_i.fall(1'b1);
		rdc(12'h000, 32'h07);
		apb(1'b1, 12'h008, 32'h00AA);
		apb(1'b1, 12'h004, 32'h5555);
		apb(1'b1, 12'h000, 32'h0E);
		crt_pin_model_i.fall(1'b1);
		rdc(12'h004, 32'h00AA);
		rdc(12'h000, 32'h4E);
		apb(1'b1, 12'h008, 32'hFFFE);
		apb(1'b1, 12'h004, 32'hFFFE);
		nRx = 0;
		nTx = 0;
		apb(1'b1, 12'h000, 32'h35);
		repeat (240) @(posedge mclk);
		rdc(12'h000, 32'h35);
		check(nRx inside {[9:11]}, 1'b1);
		check(nTx == nRx, 1'b1);
		apb(1'b1, 12'h000, 32'h0);
		// Let a baud pulse launched before the stop drain first
		repeat (2) @(posedge mclk);
		nRx = 0;
		nTx = 0;
		crt_pin_model_i.other_pulse();
		repeat (3) @(posedge mclk);
		check(nRx, 1);
		check(nTx, 1);
		stop_test();
	end
endmodule // crt_timer_tb_top
